// File: rtl/nmb_seq.sv
// Purpose: splits processor requests into bus cycles with byte lane selects
// Assumes: bus pins arrive from outside the clock domain
// Notes:   address and data paths stay with the caller; only lanes and word index
`timescale 1ns/1ns

module nmb_seq (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // request side
  input  wire logic              req_valid_i,
  input  wire nmb_pkg::nmb_req_t req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  // bus pins
  input  wire logic              bus_ready_n_i,
  input  wire logic              width16_n_i,
  input  wire logic              width8_n_i,
  output nmb_pkg::nmb_bus_t      bus_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // ready and size pins come from the system decode, not this clock
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // inactive after reset, so no false cycle end follows it
      pin_s1_ff <= nmb_pkg::PIN_SYNC_RST;
      pin_s2_ff <= nmb_pkg::PIN_SYNC_RST;
    end else begin
      pin_s1_ff <= {bus_ready_n_i, width16_n_i, width8_n_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic rdy_n;
  logic w16_n;
  logic w8_n;

  // widths ride the same sample as ready, so a cycle splits on its own answer
  assign rdy_n = pin_s2_ff[2];
  assign w16_n = pin_s2_ff[1];
  assign w8_n  = pin_s2_ff[0];

  // ****************************************
  // sequencer state
  // ****************************************
  nmb_pkg::nmb_state_t state_ff;
  nmb_pkg::nmb_state_t nxt_state;
  logic [3:0]          lanes_n_ff;
  logic [3:0]          nxt_lanes_n;
  logic [3:0]          pend_n_ff;
  logic [3:0]          nxt_pend_n;
  logic [1:0]          word_ff;
  logic [1:0]          nxt_word;
  logic                fill_ff;
  logic                nxt_fill;
  logic                first_ff;
  logic                nxt_first;
  logic                start_ff;
  logic                nxt_start;
  logic                done_ff;
  logic                nxt_done;

  logic [3:0] split_n;
  logic       split_more;

  // split decision comes from the synced widths, never the raw pins
  nmb_lane_next u_lane_next (
    .cur_n_i     (lanes_n_ff),
    .width16_n_i (w16_n),
    .width8_n_i  (w8_n),
    .nxt_n_o     (split_n),
    .more_o      (split_more)
  );

  // operand laid over eight lanes; the upper nibble spills into the next word
  logic [7:0] span;
  logic [7:0] placed;

  always_comb begin
    case (req_i.len_code)
      nmb_pkg::LEN_1: span = nmb_pkg::SPAN_1;
      nmb_pkg::LEN_2: span = nmb_pkg::SPAN_2;
      default:        span = nmb_pkg::SPAN_4;
    endcase
    placed = span << req_i.offset;
  end

  // a line fill ignores length and offset; it always moves four words
  always_comb begin
    nxt_state   = state_ff;
    nxt_lanes_n = lanes_n_ff;
    nxt_pend_n  = pend_n_ff;
    nxt_word    = word_ff;
    nxt_fill    = fill_ff;
    nxt_first   = first_ff;
    nxt_start   = 1'b0;
    nxt_done    = 1'b0;
    case (state_ff)
      nmb_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          nxt_state = nmb_pkg::ST_BUS;
          nxt_start = 1'b1;
          nxt_word  = nmb_pkg::WORD_RST;
          nxt_fill  = req_i.fill;
          nxt_first = req_i.fill;
          if (req_i.fill) begin
            // whole words, all lanes on the first fill cycle
            nxt_lanes_n = nmb_pkg::LANES_ALL_N;
            nxt_pend_n  = nmb_pkg::LANES_NONE_N;
          end else if (placed[7:4] != 4'h0) begin
            // spill into next word goes out before the low remainder
            nxt_lanes_n = ~placed[7:4];
            nxt_pend_n  = ~placed[3:0];
            nxt_word    = 2'h1;
          end else begin
            // contiguous lanes of the operand only
            nxt_lanes_n = ~placed[3:0];
            nxt_pend_n  = nmb_pkg::LANES_NONE_N;
          end
        end
      end
      nmb_pkg::ST_BUS: begin
        // ready is seen two edges late; the system must drop it in time
        if (!rdy_n) begin
          nxt_start = 1'b1;
          nxt_first = 1'b0;
          if (split_more) begin
            // narrow device: rest of this word next, low part first
            nxt_lanes_n = split_n;
          end else if (pend_n_ff != nmb_pkg::LANES_NONE_N) begin
            // low-order remainder after the high part
            nxt_lanes_n = pend_n_ff;
            nxt_pend_n  = nmb_pkg::LANES_NONE_N;
            nxt_word    = 2'h0;
          end else if (fill_ff && word_ff != nmb_pkg::FILL_LAST_WD) begin
            // next word of the line, up to sixteen byte cycles overall
            nxt_lanes_n = nmb_pkg::LANES_ALL_N;
            nxt_word    = word_ff + 2'h1;
          end else begin
            nxt_state   = nmb_pkg::ST_IDLE;
            nxt_start   = 1'b0;
            nxt_done    = 1'b1;
            nxt_fill    = 1'b0;
            nxt_lanes_n = nmb_pkg::LANES_NONE_N;
          end
        end
      end
      default: begin
        nxt_state   = nmb_pkg::ST_IDLE;
        nxt_lanes_n = nmb_pkg::LANES_NONE_N;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff   <= nmb_pkg::ST_IDLE;
      lanes_n_ff <= nmb_pkg::LANES_NONE_N;
      pend_n_ff  <= nmb_pkg::LANES_NONE_N;
      word_ff    <= nmb_pkg::WORD_RST;
      fill_ff    <= 1'b0;
      first_ff   <= 1'b0;
      start_ff   <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      lanes_n_ff <= nxt_lanes_n;
      pend_n_ff  <= nxt_pend_n;
      word_ff    <= nxt_word;
      fill_ff    <= nxt_fill;
      first_ff   <= nxt_first;
      start_ff   <= nxt_start;
      done_ff    <= nxt_done;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // ready is combinational so a request is taken the edge it is seen
  assign req_ready_o = (state_ff == nmb_pkg::ST_IDLE);
  // done is registered, one clock after the last cycle end
  assign done_o      = done_ff;

  // lanes move only when a request is taken or at a cycle end, so the system decode sees them settled
  always_comb begin
    bus_o.start         = start_ff;
    bus_o.active        = (state_ff == nmb_pkg::ST_BUS);
    bus_o.first_fill    = first_ff;
    bus_o.word          = word_ff;
    bus_o.lane_select_n = lanes_n_ff;
  end

endmodule

// File: rtl/nmb_pkg.sv
// Purpose: shared types and constants for the narrow bus cycle sequencer
// Assumes: 32-bit processor bus, four active-low byte lanes
// Notes:   no registers reachable by software
package nmb_pkg;

  // ****************************************
  // operand length codes
  // ****************************************
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_4 = 2'h2;

  // ****************************************
  // lane patterns and reset values
  // ****************************************
  localparam logic [3:0] LANES_NONE_N  = 4'hF;
  localparam logic [3:0] LANES_ALL_N   = 4'h0;
  localparam logic [7:0] SPAN_1        = 8'h01;
  localparam logic [7:0] SPAN_2        = 8'h03;
  localparam logic [7:0] SPAN_4        = 8'h0F;
  localparam logic [1:0] FILL_LAST_WD  = 2'h3;
  localparam logic [1:0] WORD_RST      = 2'h0;
  localparam logic [2:0] PIN_SYNC_RST  = 3'h7;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       fill;
    logic [1:0] len_code;
    logic [1:0] offset;
  } nmb_req_t;

  typedef struct packed {
    logic       start;
    logic       active;
    logic       first_fill;
    logic [1:0] word;
    logic [3:0] lane_select_n;
  } nmb_bus_t;

  typedef enum logic {
    ST_IDLE,
    ST_BUS
  } nmb_state_t;

endpackage

// File: rtl/nmb_lane_next.sv
// Purpose: next lane pattern after a bus cycle narrowed by a size input
// Assumes: lane pattern is contiguous
// Notes:   purely combinational
`timescale 1ns/1ns
module nmb_lane_next (
  // current cycle
  input  wire logic [3:0] cur_n_i,
  input  wire logic       width16_n_i,
  input  wire logic       width8_n_i,
  // next cycle
  output logic [3:0]      nxt_n_o,
  output logic            more_o
);

  logic [3:0] act;
  logic [3:0] low_one;

  always_comb begin
    act     = ~cur_n_i;
    low_one = act & (~act + 4'h1);
    nxt_n_o = cur_n_i;
    more_o  = 1'b0;
    if (!width8_n_i) begin
      // byte wide wins when both inputs are low
      // lowest byte goes first, one lane per cycle
      more_o  = (act != low_one);
      nxt_n_o = cur_n_i | low_one;
    end else if (!width16_n_i) begin
      // lower half word first, upper half rides its own lanes
      more_o  = (act[1:0] != 2'h0) && (act[3:2] != 2'h0);
      nxt_n_o = cur_n_i | 4'h3;
    end
  end

endmodule

// File: tb/nmb_seq_checker.sv
// Purpose: port checks for the bus cycle sequencer
// Assumes: pins pass its own 2FF synchronisers
// Notes:   bound at the foot
`timescale 1ns/1ns
module nmb_seq_checker (
  input wire logic              core_clk_i,
  input wire logic              resetn_i,
  input wire logic              req_valid_i,
  input wire nmb_pkg::nmb_req_t req_i,
  input wire logic              req_ready_o,
  input wire logic              done_o,
  input wire logic              bus_ready_n_i,
  input wire logic              width16_n_i,
  input wire logic              width8_n_i,
  input wire nmb_pkg::nmb_bus_t bus_o
);
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [3:0] on;
  logic       ac;
  logic       st;
  assign on = ~bus_o.lane_select_n;
  assign ac = bus_o.active;
  assign st = bus_o.start;
  property p_gap; ac |-> on inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF}; endproperty
  a_gap: assert property (p_gap) else $error("lane gap");
  property p_idle; !ac |-> on == 4'h0 && !st; endproperty
  a_idle: assert property (p_idle) else $error("idle lanes");
  property p_fill; bus_o.first_fill |-> on == 4'hF && bus_o.word == 2'h0; endproperty
  a_fill: assert property (p_fill) else $error("fill start");
  property p_take; req_valid_i && req_ready_o |=> st && ac && !req_ready_o; endproperty
  a_take: assert property (p_take) else $error("no start");
  property p_hold; ac && !st |-> $stable(on) && $stable(bus_o.word); endproperty
  a_hold: assert property (p_hold) else $error("lanes moved");
  // narrowed cycle keeps only higher lanes of the same word
  property p_low; st && $past(ac) && !$past(done_o) && bus_o.word == $past(bus_o.word)
    |-> (on & $past(bus_o.lane_select_n)) == 4'h0 && (on ^ ~$past(bus_o.lane_select_n)) < on; endproperty
  a_low: assert property (p_low) else $error("bad narrow");
  property p_done; done_o |-> req_ready_o ##1 !done_o [*2]; endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_busy; st |-> !req_ready_o && !done_o; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  c_fill: cover property (bus_o.first_fill);
  c_b2b: cover property (done_o && req_valid_i);
  c_split: cover property (st && $past(ac));
endmodule
bind nmb_seq nmb_seq_checker nmb_seq_checker_i (.*);

// File: tb/nmb_mem_model.sv
// Purpose: memory system answering sequencer bus cycles
// Assumes: one array width per request
// Notes:   ready is one low clock; idle pins rest high
`timescale 1ns/1ns
module nmb_mem_model (
  // clock, control
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [1:0]        mode_i,
  input  wire logic              slow_i,
  // bus pins
  input  wire nmb_pkg::nmb_bus_t bus_i,
  output logic                   bus_ready_n_o,
  output logic                   width16_n_o,
  output logic                   width8_n_o,
  // narrow array address and data steering
  output logic                   half_sel_o,
  output logic                   upper_lane_en_n_o,
  output logic                   lower_lane_en_n_o,
  output logic [1:0]             steer_lane_o
);
  logic [3:0] wait_ff;
  logic [2:0] dec;
  // lower enable doubles as A0 for byte-wide arrays
  always_comb begin
    case (bus_i.lane_select_n)
      4'hE:             dec = 3'h2;
      4'hD, 4'h9, 4'h1: dec = 3'h1;
      4'hC, 4'h8, 4'h0: dec = 3'h0;
      4'hB:             dec = 3'h6;
      4'h7:             dec = 3'h5;
      4'h3:             dec = 3'h4;
      default:          dec = 3'h7; // gaps and no lanes are free choices
    endcase
    // first fill cycle decoded as a whole word
    if (bus_i.first_fill)
      dec = 3'h0;
  end
  assign {half_sel_o, upper_lane_en_n_o, lower_lane_en_n_o} = dec;
  // narrow data byte is swapped onto processor lane {A1, A0}
  assign steer_lane_o = {dec[2], dec[0]};
  // mode 0 full width, 1 half, 2 byte, 3 both low
  assign width16_n_o = !mode_i[0];
  assign width8_n_o  = !mode_i[1];
  always @(negedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_ff <= 4'h0;
      bus_ready_n_o <= 1'b1;
    end else begin
      // single low clock so the synchroniser sees one end
      bus_ready_n_o <= wait_ff != 4'h1;
      if (bus_i.start)
        wait_ff <= slow_i ? 4'h5 : 4'h1;
      else if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule

// File: tb/nmb_seq_tb.sv
// Purpose: self-checking bench for the bus cycle sequencer
// Assumes: memory model answers each cycle
// Notes:   corner table, then xorshift traffic
`timescale 1ns/1ns
module nmb_seq_tb;
  // ****
  // bench
  // ****
  logic              core_clk_i  = 1'b0;
  logic              resetn_i    = 1'b0;
  logic              req_valid_i = 1'b0;
  logic              slow        = 1'b0;
  logic [1:0]        mode        = 2'h0;
  logic [31:0]       rng         = 32'h0000BF79;
  nmb_pkg::nmb_req_t req_i       = '0;
  logic              req_ready_o, done_o, rdy_n, w16_n, w8_n;
  nmb_pkg::nmb_bus_t bus_o;
  logic              half_sel, upper_lane_en_n, lower_lane_en_n;
  logic [1:0]        steer;
  int                miscompares = 0;
  int                checked     = 0;
  logic [7:0]        expq[$];
  nmb_seq nmb_seq_i (.core_clk_i, .resetn_i, .req_valid_i, .req_i, .req_ready_o, .done_o,
    .bus_ready_n_i(rdy_n), .width16_n_i(w16_n), .width8_n_i(w8_n), .bus_o);
  nmb_mem_model nmb_mem_model_i (.core_clk_i, .resetn_i, .mode_i(mode), .slow_i(slow), .bus_i(bus_o),
    .bus_ready_n_o(rdy_n), .width16_n_o(w16_n), .width8_n_o(w8_n), .half_sel_o(half_sel),
    .upper_lane_en_n_o(upper_lane_en_n), .lower_lane_en_n_o(lower_lane_en_n), .steer_lane_o(steer));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // half word select goes high only when both low lanes are idle
  function automatic logic [7:0] dec_exp(logic [3:0] s, logic f);
    logic a1;
    a1 = s[0] & s[1];
    return f ? 8'h00 : {5'h0, a1, a1 ? s[3] : s[1], a1 ? s[2] : s[0]};
  endfunction
  // narrow data byte belongs to the lowest enabled lane
  function automatic logic [1:0] low_lane(logic [3:0] s);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (!s[i]) r = 2'(i);
    return r;
  endfunction
  // queue the expected cycles, then issue and wait for done
  task automatic run(nmb_pkg::nmb_req_t r);
    logic [7:0] sp;
    logic [3:0] m;
    logic       ff;
    int         n;
    sp = (r.len_code == nmb_pkg::LEN_4 ? nmb_pkg::SPAN_4 : r.len_code == nmb_pkg::LEN_2 ? nmb_pkg::SPAN_2
      : nmb_pkg::SPAN_1) << r.offset;
    ff = r.fill;
    for (int i = 0; i < 4; i++) begin
      m = r.fill ? 4'hF : i == 0 ? sp[7:4] : i == 1 ? sp[3:0] : 4'h0;
      while (m != 4'h0) begin
        expq.push_back({1'b0, ff, r.fill ? 2'(i) : 2'(1 - i), ~m});
        ff = 1'b0;
        // both size pins low counts as byte wide
        if (mode == 2'h1) m = (m[1:0] != 2'h0 && m[3:2] != 2'h0) ? m & 4'hC : 4'h0;
        else m = mode == 2'h0 ? 4'h0 : m & (m - 4'h1);
      end
    end
    chk({7'h0, req_ready_o}, 8'h01);
    req_i = r;
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    for (n = 0; n < 300 && done_o !== 1'b1; n++) @(negedge core_clk_i);
    if (n == 300) begin
      miscompares++;
      complete_run();
    end
    chk(8'(expq.size()), 8'h00);
  endtask
  always @(negedge core_clk_i) begin
    if (resetn_i && bus_o.start === 1'b1) begin
      if (expq.size() == 0) chk(8'hFF, 8'h00);
      else chk({1'b0, bus_o.first_fill, bus_o.word, bus_o.lane_select_n}, expq.pop_front());
      chk({5'h0, half_sel, upper_lane_en_n, lower_lane_en_n}, dec_exp(bus_o.lane_select_n, bus_o.first_fill));
      chk({6'h0, steer}, {6'h0, low_lane(bus_o.lane_select_n)});
    end
  end
  initial begin
    logic [31:0] v;
    repeat (3) @(negedge core_clk_i);
    resetn_i = 1'b1;
    for (int k = 0; k < 64; k++) begin
      mode = k[5:4];
      slow = k[0];
      run({k[3:2] == 2'h3, k[3:2], k[1:0]});
    end
    for (int k = 0; k < 80; k++) begin
      v = xs();
      mode = v[1:0];
      slow = v[2];
      run({v[3] & v[4], v[6:5] == 2'h3 ? nmb_pkg::LEN_4 : v[6:5], v[8:7]});
    end
    complete_run();
  end
endmodule
